/* core/flash_erase_host.sv */
// Host sequencer issuing erase, pause and continue commands to the flash
//
// Operation
// RULE_01: Block erase set-up after two unlocks
// RULE_02: Sixth write: block confirm at target block
// RULE_03: Extra block confirms need no unlock cycles
// RULE_04: Confirms restart timeout before erasing
// RULE_05: Timer flag low while timeout runs
// RULE_06: Bad confirm or unlock aborts to array read
// RULE_07: Device pre-programs zeros itself
// RULE_08: Reads return status after sixth write
// RULE_09: Erasing device takes only pause or read/reset
// RULE_10: Polling flag zero busy, one when done
// RULE_11: Toggle flags change until erase completes
// RULE_12: Failure flag set; host then issues read/reset; host only sets fail and idles, software issues read/reset
// RULE_13: Chip erase: six writes, chip confirm
// RULE_14: Pause is one write, any address
// RULE_15: Pause honoured only during block erase
// RULE_16: Pause during timeout also ends timeout
// RULE_17: Toggles stop within window after pause
// RULE_18: Paused reads of erasing block show toggling
// RULE_19: Paused device takes only continue and program; model takes continue and read/reset, no program
// RULE_20: Read/reset while paused cancels erase
// RULE_21: Address on strobe fall, data on rise
// RULE_22: Continue is one write, any address
// RULE_23: Host sends two unlock writes before erase set-up and before erase confirm
`timescale 1ns/10ps
module flash_erase_host #(
    parameter int PAUSE_WAIT = flash_erase_pkg::PAUSE_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic [flash_erase_pkg::ADDR_W-1:0] flash_addr,
    output logic [flash_erase_pkg::DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [flash_erase_pkg::DATA_W-1:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    input wire logic ready_busy_out,
    output logic reset_unprotect_pin
);
    import flash_erase_pkg::*;
    typedef enum logic [2:0] {
        H_IDLE, H_ISSUE, H_WAIT, H_POLL, H_PAUSE_WAIT
    } host_state_t;
    typedef enum logic [1:0] {
        M_IDLE, M_TIMEOUT, M_PAUSED
    } erase_mode_t;

    host_state_t state_reg, state_next;
    erase_mode_t mode_reg, mode_next;
    host_op_t op_reg, op_next;
    logic [2:0] step_reg, step_next;
    logic [2:0] nsteps_reg, nsteps_next;
    logic [ADDR_W-1:0] tgt_reg, tgt_next;
    logic byte_mode_reg, byte_mode_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [DATA_W-1:0] last_stat_reg, last_stat_next;
    logic [15:0] pwait_reg, pwait_next;
    logic done_reg, done_next;
    logic fail_reg, fail_next;
    logic [31:0] sw_rdata_reg, sw_rdata_next;
    logic cyc_start;
    bus_cyc_t cyc;
    logic cyc_busy, cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    flash_status_t stat;

    flash_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .srst(srst),
        .start(cyc_start),
        .cyc(cyc),
        .dq_in(flash_dq_in),
        .busy(cyc_busy),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .addr(flash_addr),
        .dq_out(flash_dq_out),
        .dq_oe(flash_dq_oe),
        .ce_n(flash_ce_n),
        .we_n(flash_we_n),
        .oe_n(flash_oe_n)
    );

    assign stat.polling_flag = cyc_rdata[POLL_BIT];
    assign stat.op_toggle_flag = cyc_rdata[OPTOG_BIT];
    assign stat.failure_flag = cyc_rdata[FAIL_BIT];
    assign stat.erase_timer_flag = cyc_rdata[TIMER_BIT];
    assign stat.block_toggle_flag = cyc_rdata[BLKTOG_BIT];

    // Bus cycle for the current step
    always_comb begin
        cyc = '0;
        cyc.addr = tgt_reg;
        cyc.write = 1'b1;
        case (op_reg)
            OP_BLOCK_WIPE, OP_CHIP_WIPE: begin
                case (step_reg)
                    3'h0, 3'h3: begin // RULE_23
                        cyc.addr = UNLOCK1_ADDR;
                        cyc.data = UNLOCK1_DATA;
                    end
                    3'h1, 3'h4: begin // RULE_23
                        cyc.addr = UNLOCK2_ADDR;
                        cyc.data = UNLOCK2_DATA;
                    end
                    3'h2: begin // RULE_01
                        cyc.addr = byte_mode_reg ? SETUP_ADDR_BYTE
                                                 : SETUP_ADDR_WORD;
                        cyc.data = ERASE_SETUP_CODE;
                    end
                    default: begin
                        if (op_reg == OP_CHIP_WIPE) begin
                            cyc.addr = UNLOCK1_ADDR;
                            cyc.data = CHIP_CONFIRM_CODE; // RULE_13
                        end else begin
                            cyc.data = BLOCK_CONFIRM_CODE; // RULE_02
                        end
                    end
                endcase
            end
            OP_ADD_BLOCK: begin
                cyc.data = BLOCK_CONFIRM_CODE; // RULE_03
            end
            OP_PAUSE: begin
                cyc.data = PAUSE_CODE; // RULE_14
            end
            OP_CONTINUE: begin
                cyc.data = CONTINUE_CODE; // RULE_22
            end
            OP_READ_RESET: begin
                cyc.data = READ_RESET_CODE;
            end
            default: begin
                cyc.write = 1'b0;
            end
        endcase
    end

    assign cyc_start = (state_reg == H_ISSUE) && !cyc_busy;

    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        op_next = op_reg;
        step_next = step_reg;
        nsteps_next = nsteps_reg;
        tgt_next = tgt_reg;
        byte_mode_next = byte_mode_reg;
        rdata_next = rdata_reg;
        last_stat_next = last_stat_reg;
        pwait_next = pwait_reg;
        done_next = done_reg;
        fail_next = fail_reg;
        sw_rdata_next = 32'h0000_0000;
        if (sw_wr && sw_addr == REG_ADDR) begin
            tgt_next = sw_wdata[ADDR_W-1:0];
            byte_mode_next = sw_wdata[31];
        end
        case (state_reg)
            H_IDLE: begin
                if (sw_wr && sw_addr == REG_CTRL &&
                    host_op_t'(sw_wdata[2:0]) != OP_NONE) begin
                    op_next = host_op_t'(sw_wdata[2:0]);
                    step_next = 3'h0;
                    done_next = 1'b0;
                    case (host_op_t'(sw_wdata[2:0]))
                        OP_BLOCK_WIPE, OP_CHIP_WIPE: nsteps_next = 3'h6;
                        default: nsteps_next = 3'h1;
                    endcase
                    state_next = H_ISSUE;
                end
            end
            H_ISSUE: begin
                if (!cyc_busy && op_reg == OP_READ && step_reg != 3'h0)
                    state_next = H_POLL;
                else if (!cyc_busy)
                    state_next = H_WAIT;
            end
            H_WAIT: begin
                if (cyc_done) begin
                    if (op_reg == OP_READ) begin
                        rdata_next = cyc_rdata;
                        state_next = H_IDLE;
                        done_next = 1'b1;
                    end else if (step_reg + 3'h1 < nsteps_reg) begin
                        step_next = step_reg + 3'h1;
                        state_next = H_ISSUE;
                    end else begin
                        case (op_reg)
                            // Block erase may still take more blocks
                            OP_BLOCK_WIPE, OP_ADD_BLOCK:
                                mode_next = M_TIMEOUT; // RULE_04
                            OP_PAUSE: begin
                                pwait_next = 16'(PAUSE_WAIT);
                                mode_next = M_PAUSED; // RULE_16
                            end
                            OP_CONTINUE: mode_next = M_TIMEOUT;
                            default: mode_next = M_IDLE; // RULE_20
                        endcase
                        if (op_reg == OP_PAUSE)
                            state_next = H_PAUSE_WAIT; // RULE_17
                        else if (op_reg == OP_READ_RESET) begin
                            state_next = H_IDLE;
                            done_next = 1'b1;
                            fail_next = 1'b0; // RULE_12
                        end else begin
                            op_next = OP_READ;
                            step_next = 3'h0;
                            state_next = H_POLL; // RULE_08
                        end
                    end
                end
            end
            H_POLL: begin
                // Two reads in a row; toggling means still busy
                if (!cyc_busy && !cyc_start && step_reg == 3'h0) begin
                    step_next = 3'h1;
                    state_next = H_ISSUE;
                    nsteps_next = 3'h1;
                end else if (cyc_done) begin
                    last_stat_next = cyc_rdata;
                    if ((step_reg == 3'h2 && // RULE_11
                         last_stat_reg[OPTOG_BIT] == stat.op_toggle_flag &&
                         last_stat_reg[BLKTOG_BIT] == stat.block_toggle_flag)
                        || (stat.polling_flag && stat.erase_timer_flag) // RULE_10
                        || (stat.failure_flag && !stat.polling_flag)) begin
                        fail_next = fail_reg || (stat.failure_flag &&
                            !stat.polling_flag); // RULE_12
                        mode_next = M_IDLE;
                        state_next = H_IDLE;
                        done_next = 1'b1;
                    end else begin
                        step_next = 3'h2;
                        state_next = H_ISSUE;
                    end
                end
            end
            H_PAUSE_WAIT: begin
                if (pwait_reg <= 16'h0001) begin
                    state_next = H_IDLE;
                    done_next = 1'b1;
                end else begin
                    pwait_next = pwait_reg - 16'h0001;
                end
            end
            default: state_next = H_IDLE;
        endcase
        if (sw_rd) begin
            case (sw_addr)
                REG_ADDR: sw_rdata_next = {byte_mode_reg, 13'h0000, tgt_reg};
                REG_STATUS: sw_rdata_next = {24'h000000,
                    ready_busy_out, 1'b0, mode_reg, fail_reg, done_reg,
                    (state_reg != H_IDLE), 1'b0};
                REG_RDATA: sw_rdata_next = {16'h0000, rdata_reg};
                default: sw_rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= H_IDLE;
            mode_reg <= M_IDLE;
            op_reg <= OP_NONE;
            step_reg <= 3'h0;
            nsteps_reg <= 3'h0;
            tgt_reg <= '0;
            byte_mode_reg <= 1'b0;
            rdata_reg <= '0;
            last_stat_reg <= '0;
            pwait_reg <= 16'h0000;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            sw_rdata_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            op_reg <= op_next;
            step_reg <= step_next;
            nsteps_reg <= nsteps_next;
            tgt_reg <= tgt_next;
            byte_mode_reg <= byte_mode_next;
            rdata_reg <= rdata_next;
            last_stat_reg <= last_stat_next;
            pwait_reg <= pwait_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            sw_rdata_reg <= sw_rdata_next;
        end
    end

    assign sw_rdata = sw_rdata_reg;
    // Reset pin held inactive; pulsing it is left to board logic
    assign reset_unprotect_pin = 1'b1;
endmodule : flash_erase_host

/* core/flash_erase_pkg.sv */
// Package: flash erase host constants, types and timing counts
package flash_erase_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    // Unlock cycle values are a property of the part; defaults are arbitrary
    localparam logic [17:0] UNLOCK1_ADDR = 18'h05555;
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [17:0] UNLOCK2_ADDR = 18'h02aaa;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [17:0] SETUP_ADDR_BYTE = 18'h0aaaa;
    localparam logic [17:0] SETUP_ADDR_WORD = 18'h05555;
    localparam logic [15:0] ERASE_SETUP_CODE = 16'h0080;
    localparam logic [15:0] BLOCK_CONFIRM_CODE = 16'h0030;
    localparam logic [15:0] CHIP_CONFIRM_CODE = 16'h0010;
    localparam logic [15:0] PAUSE_CODE = 16'h00b0;
    localparam logic [15:0] CONTINUE_CODE = 16'h0030;
    localparam logic [15:0] READ_RESET_CODE = 16'h00f0;
    // Status bit positions on the data lines
    localparam int POLL_BIT = 7;
    localparam int OPTOG_BIT = 6;
    localparam int FAIL_BIT = 5;
    localparam int TIMER_BIT = 3;
    localparam int BLKTOG_BIT = 2;
    // Bus timing, slowest grade, in ns
    localparam int CLK_NS = 10;
    localparam int WE_LOW_NS = 65;
    localparam int WE_HIGH_NS = 35;
    localparam int READ_NS = 150;
    localparam int PAUSE_MAX_NS = 15000;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAUSE_MAX_CYC = PAUSE_MAX_NS / CLK_NS;
    // Software register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    // Control opcodes written to REG_CTRL
    typedef enum logic [2:0] {
        OP_NONE, OP_BLOCK_WIPE, OP_ADD_BLOCK, OP_CHIP_WIPE,
        OP_PAUSE, OP_CONTINUE, OP_READ_RESET, OP_READ
    } host_op_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic write;
    } bus_cyc_t;
    typedef struct packed {
        logic polling_flag;
        logic op_toggle_flag;
        logic failure_flag;
        logic erase_timer_flag;
        logic block_toggle_flag;
    } flash_status_t;
endpackage : flash_erase_pkg

/* core/flash_bus_cycle.sv */
// One asynchronous flash bus cycle, write or read, timed from sys_clk
`timescale 1ns/10ps
module flash_bus_cycle (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic start,
    input flash_erase_pkg::bus_cyc_t cyc,
    input wire logic [flash_erase_pkg::DATA_W-1:0] dq_in,
    output logic busy,
    output logic done,
    output logic [flash_erase_pkg::DATA_W-1:0] rdata,
    output logic [flash_erase_pkg::ADDR_W-1:0] addr,
    output logic [flash_erase_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic ce_n,
    output logic we_n,
    output logic oe_n
);
    import flash_erase_pkg::*;
    typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} cyc_state_t;
    cyc_state_t state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    bus_cyc_t cur_reg, cur_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic done_reg, done_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cur_next = cur_reg;
        rdata_next = rdata_reg;
        done_next = 1'b0;
        case (state_reg)
            C_IDLE: begin
                if (start) begin
                    cur_next = cyc;
                    state_next = C_LOW;
                    cnt_next = cyc.write ? 8'(WE_LOW_CYC) : 8'(READ_CYC);
                end
            end
            C_LOW: begin
                // Address held from strobe fall; data taken at strobe rise
                if (cnt_reg <= 8'h01) begin // RULE_21
                    if (!cur_reg.write)
                        rdata_next = dq_in;
                    state_next = C_HIGH;
                    cnt_next = 8'(WE_HIGH_CYC);
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            C_HIGH: begin
                if (cnt_reg <= 8'h01) begin
                    state_next = C_IDLE;
                    done_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: state_next = C_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= C_IDLE;
            cnt_reg <= 8'h00;
            cur_reg <= '0;
            rdata_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cur_reg <= cur_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
        end
    end

    assign busy = (state_reg != C_IDLE);
    assign done = done_reg;
    assign rdata = rdata_reg;
    assign addr = cur_reg.addr;
    assign dq_out = cur_reg.data;
    // Data bus held through the recovery phase to cover hold time
    assign dq_oe = busy && cur_reg.write;
    assign ce_n = !busy;
    assign we_n = !(state_reg == C_LOW && cur_reg.write);
    assign oe_n = !(state_reg == C_LOW && !cur_reg.write);
endmodule : flash_bus_cycle

/* sim/flash_erase_host_asserts.sv */
// Checker for the flash erase host pin timing and register port
`timescale 1ns/10ps
module flash_erase_host_asserts (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sw_rd,
    input wire logic [31:0] sw_rdata,
    input wire logic [flash_erase_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [flash_erase_pkg::DATA_W-1:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    input wire logic reset_unprotect_pin
);
    import flash_erase_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_reset_idle: assert property (disable iff (1'b0) srst |=> flash_ce_n
        && flash_we_n && flash_oe_n && !flash_dq_oe)
        else $error("bus busy after reset");
    a_we_with_ce: assert property (!flash_we_n |->
        !flash_ce_n && flash_oe_n) else $error("we_n low without ce_n");
    a_we_drives_dq: assert property (!flash_we_n |-> flash_dq_oe)
        else $error("dq not driven in write");
    a_we_low_width: assert property ($fell(flash_we_n) |->
        (!flash_we_n)[*7] ##1 flash_we_n) else $error("we_n low width");
    a_we_high_gap: assert property ($rose(flash_we_n) |->
        flash_we_n[*4]) else $error("we_n high gap short");
    a_addr_held: assert property (!flash_we_n &&
        !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
        else $error("addr or data moved");
    a_data_hold: assert property ($rose(flash_we_n) |->
        flash_dq_oe && $stable(flash_dq_out)) else $error("no data hold");
    a_read_len: assert property ($fell(flash_oe_n) |->
        (!flash_oe_n && !flash_ce_n && flash_we_n)[*8])
        else $error("read too short");
    a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
        else $error("stale read data");
    a_pin_quiet: assert property (reset_unprotect_pin)
        else $error("reset pin driven low");
    c_write: cover property ($fell(flash_we_n));
    c_read: cover property ($fell(flash_oe_n));
    c_fail: cover property (sw_rd ##1 sw_rdata[3]);
endmodule : flash_erase_host_asserts
bind flash_erase_host flash_erase_host_asserts chk_u (
    .sys_clk(sys_clk), .srst(srst), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .reset_unprotect_pin(reset_unprotect_pin)
);

/* sim/flash_dev_model.sv */
// Behavioural flash device: command decode, erase timer and status flags
`timescale 1ns/10ps
module flash_dev_model #(
    parameter int TMO_NS = 2000,
    parameter int ERASE_NS = 20000
) (
    input wire logic [flash_erase_pkg::ADDR_W-1:0] addr,
    input wire logic [flash_erase_pkg::DATA_W-1:0] dq_host,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic fail_en,
    output logic [flash_erase_pkg::DATA_W-1:0] dq_dev,
    output logic ready_busy_out
);
    import flash_erase_pkg::*;
    logic [17:0] wlog_a[$];
    logic [15:0] wlog_d[$];
    logic [63:0] target = '0;
    logic [63:0] wiped = '0;
    logic [17:0] la = '0;
    logic [15:0] rd_val = '0;
    logic [15:0] last = '0;
    logic timing = 0, erasing = 0, paused = 0, failed = 0, tog = 0, chip = 0;
    int step = 0;
    int gen = 0;
    assign ready_busy_out = !(timing || erasing);
    // Released bus shows the inverse of its last value
    assign dq_dev = (!ce_n && !oe_n) ? rd_val : ~last;
    task automatic arm(input int ns);
        int id;
        gen++;
        id = gen;
        fork
            begin
                #(ns);
                if (id == gen) expire();
            end
        join_none
    endtask : arm
    task automatic expire();
        if (timing) begin
            timing = 0;
            erasing = 1;
            arm(ERASE_NS);
        end else if (erasing) begin
            erasing = 0;
            if (fail_en) failed = 1;
            else wiped = wiped | target;
        end
    endtask : expire
    task automatic decode(input logic [17:0] a, input logic [15:0] d);
        logic ok;
        if (timing || erasing) begin
            if (d == READ_RESET_CODE) begin
                timing = 0;
                erasing = 0;
                gen++;
            end else if (d == PAUSE_CODE && !chip) begin
                timing = 0;
                erasing = 0;
                paused = 1;
                gen++;
            end else if (timing && d == BLOCK_CONFIRM_CODE) begin
                target[a[17:12]] = 1'b1;
                arm(TMO_NS);
            end
        end else if (paused) begin
            if (d == CONTINUE_CODE) begin
                paused = 0;
                erasing = 1;
                arm(ERASE_NS);
            end else if (d == READ_RESET_CODE) begin
                paused = 0;
                target = '0;
            end
        end else if (failed) begin
            if (d == READ_RESET_CODE) failed = 0;
        end else begin
            case (step)
                0, 3: ok = a == UNLOCK1_ADDR && d == UNLOCK1_DATA;
                1, 4: ok = a == UNLOCK2_ADDR && d == UNLOCK2_DATA;
                2: ok = d == ERASE_SETUP_CODE && (a == SETUP_ADDR_BYTE ||
                    a == SETUP_ADDR_WORD);
                default: ok = d == BLOCK_CONFIRM_CODE || d == CHIP_CONFIRM_CODE;
            endcase
            step = ok ? step + 1 : 0;
            if (step == 6) begin
                step = 0;
                target = '0;
                chip = d == CHIP_CONFIRM_CODE;
                if (chip) begin
                    target = '1;
                    erasing = 1;
                    arm(ERASE_NS);
                end else begin
                    target[a[17:12]] = 1'b1;
                    timing = 1;
                    arm(TMO_NS);
                end
            end
        end
    endtask : decode
    always @(negedge we_n) if (!ce_n) la = addr;
    always @(posedge we_n) begin
        if (!ce_n) begin
            wlog_a.push_back(la);
            wlog_d.push_back(dq_host);
            decode(la, dq_host);
        end
    end
    always @(negedge oe_n) begin
        if (!ce_n) begin
            tog = !tog;
            if (timing || erasing || failed)
                rd_val = {8'h00, 1'b0, tog, failed, 1'b0, erasing, tog, 2'b00};
            else if (paused && target[addr[17:12]])
                rd_val = {8'h00, 1'b0, 1'b1, 3'b000, tog, 2'b00};
            else
                rd_val = wiped[addr[17:12]] ? 16'hffff : (addr[15:0] ^ 16'h5a5a);
            last = rd_val;
        end
    end
endmodule : flash_dev_model

/* sim/tb.sv */
// Self-checking bench for the flash erase host against a device model
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb;
    import flash_erase_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0, sw_rd = 1'b0, fail_en = 1'b0, rd_seen = 1'b0;
    logic [31:0] sw_rdata;
    logic [ADDR_W-1:0] f_addr;
    logic [DATA_W-1:0] f_out, f_in, f_dev;
    logic f_oe, f_ce_n, f_we_n, f_oe_n, rdy, upin;
    int failures = 0;
    int n_compared = 0;
    logic [63:0] exp_q[$];
    always #5 sys_clk = ~sys_clk;
    assign f_in = f_oe ? f_out : f_dev;
    flash_erase_host #(.PAUSE_WAIT(5)) dut_u (.sys_clk(sys_clk), .srst(srst),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .flash_addr(f_addr), .flash_dq_out(f_out),
        .flash_dq_oe(f_oe), .flash_dq_in(f_in), .flash_ce_n(f_ce_n),
        .flash_we_n(f_we_n), .flash_oe_n(f_oe_n), .ready_busy_out(rdy),
        .reset_unprotect_pin(upin));
    flash_dev_model m_u (.addr(f_addr), .dq_host(f_out), .ce_n(f_ce_n),
        .we_n(f_we_n), .oe_n(f_oe_n), .fail_en(fail_en), .dq_dev(f_dev),
        .ready_busy_out(rdy));
    always @(posedge sys_clk) begin
        logic [63:0] n;
        if (rd_seen && exp_q.size() > 0) begin
            n = exp_q.pop_front();
            if (n[31:0] != 32'h0) `CHK(sw_rdata & n[31:0], n[63:32])
        end
        rd_seen <= sw_rd;
    end
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m,
        output logic [31:0] v);
        @(posedge sys_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        exp_q.push_back({e, m});
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask : rd
    task automatic wait_done();
        logic [31:0] v;
        int i;
        for (i = 0; i < 5000; i++) begin
            rd(REG_STATUS, 32'h0, 32'h0, v);
            if (v[2] === 1'b1 && v[1] === 1'b0) break;
        end
        if (i == 5000) begin
            failures++;
            $display("BAD t=%0t timeout", $time);
            give_verdict();
        end
    endtask : wait_done
    task automatic order(input logic [2:0] op, input int nw, input logic poke);
        int b;
        b = m_u.wlog_a.size();
        wr(REG_CTRL, {29'h0, op});
        if (poke) wr(REG_CTRL, 32'h6);
        wait_done();
        `CHK(m_u.wlog_a.size(), b + nw)
    endtask : order
    task automatic lg(input int k, input logic [17:0] a, input logic [15:0] d);
        int i;
        i = m_u.wlog_a.size() - k;
        `CHK({m_u.wlog_a[i], m_u.wlog_d[i]}, {a, d})
    endtask : lg
    initial begin
        logic [31:0] v;
        logic [17:0] tgt, a2;
        logic bm;
        void'($urandom(22));
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(REG_STATUS, 32'h80, 32'hbe, v);
        rd(4'hc, 32'h0, 32'h0, v);
        rd(REG_STATUS, 32'h80, 32'hbe, v);
        tgt = 18'($urandom);
        bm = 1'($urandom);
        a2 = tgt ^ 18'h20000;
        wr(REG_ADDR, {bm, 13'h0, tgt});
        order(3'd1, 6, 1'b1);
        lg(6, UNLOCK1_ADDR, UNLOCK1_DATA);
        lg(5, UNLOCK2_ADDR, UNLOCK2_DATA);
        lg(4, bm ? SETUP_ADDR_BYTE : SETUP_ADDR_WORD,
            ERASE_SETUP_CODE);
        lg(3, UNLOCK1_ADDR, UNLOCK1_DATA);
        lg(2, UNLOCK2_ADDR, UNLOCK2_DATA);
        lg(1, tgt, BLOCK_CONFIRM_CODE);
        rd(REG_STATUS, 32'h84, 32'hbe, v);
        wr(REG_ADDR, {14'h0, tgt});
        order(3'd7, 0, 1'b0);
        rd(REG_RDATA, 32'hffff, 32'hffff, v);
        wr(REG_ADDR, {14'h0, a2});
        order(3'd7, 0, 1'b0);
        rd(REG_RDATA, {16'h0, a2[15:0] ^ 16'h5a5a}, 32'hffff, v);
        fail_en <= 1'b1;
        order(3'd3, 6, 1'b0);
        lg(4, SETUP_ADDR_WORD, ERASE_SETUP_CODE);
        lg(1, UNLOCK1_ADDR, CHIP_CONFIRM_CODE);
        rd(REG_STATUS, 32'h0c, 32'h0e, v);
        fail_en <= 1'b0;
        order(3'd6, 1, 1'b0);
        lg(1, a2, READ_RESET_CODE);
        rd(REG_STATUS, 32'h04, 32'h0e, v);
        order(3'd4, 1, 1'b0);
        lg(1, a2, PAUSE_CODE);
        order(3'd5, 1, 1'b0);
        lg(1, a2, CONTINUE_CODE);
        order(3'd7, 0, 1'b0);
        rd(REG_RDATA, {16'h0, a2[15:0] ^ 16'h5a5a}, 32'hffff, v);
        give_verdict();
    end
endmodule : tb
